// *** hw/dtdg_pkg.sv ***
// dtdg_pkg: constants, field layout and state type of the toggle/dither generator.
// assumes one 200 MHz clock and an AHB-Lite register port with 32-bit words.
package dtdg_pkg;

  localparam int NCH = 8;
  localparam int CW = 16;
  localparam int MAGW = 6;
  localparam int LUT_AW = 5;
  localparam int LUT_FRAC = 5;

  // register byte offsets
  localparam logic [7:0] OFF_CODE = 8'h00;
  localparam logic [7:0] OFF_AB = 8'h04;
  localparam logic [7:0] OFF_TB = 8'h08;
  localparam logic [7:0] OFF_EN = 8'h0C;
  localparam logic [7:0] OFF_SET = 8'h10;
  localparam logic [7:0] OFF_DAC = 8'h30;
  localparam logic [7:0] OFF_ACT = 8'h50;
  localparam logic [7:0] OFF_BAD = 8'hFF;

  // channel settings word fields
  localparam int SET_PER_LSB = 0;
  localparam int SET_MODE_BIT = 3;
  localparam int SET_SRC_LSB = 4;
  localparam int SET_PH_LSB = 6;
  localparam int CODE_CH_LSB = 16;

  localparam logic [7:0] SET_RST = 8'h00;
  localparam logic [2:0] PER_MAX = 3'h4;
  localparam logic [1:0] SRC_SW = 2'h0;
  localparam logic [1:0] SRC_PIN0 = 2'h1;
  localparam logic [1:0] SRC_PIN1 = 2'h2;
  localparam logic [LUT_AW-1:0] LUT_TOP = 5'h10;

  typedef struct packed {
    logic [NCH-1:0][CW-1:0] a;
    logic [NCH-1:0][CW-1:0] b;
    logic [NCH-1:0][CW-1:0] dac;
    logic [NCH-1:0][7:0] set;
    logic [NCH-1:0][5:0] idx;
    logic [NCH-1:0] ab;
    logic [NCH-1:0] tb;
    logic [NCH-1:0] en;
    logic [NCH-1:0] act;
    logic [NCH-1:0] pend;
    logic [NCH-1:0] neg;
    logic [NCH-1:0] clk_prev;
    logic wr_pend;
    logic rd_pend;
    logic [7:0] addr;
    logic ready;
    logic resp;
    logic [31:0] rdata;
  } dtdg_state_t;

  typedef struct packed {
    logic [NCH-1:0][MAGW-1:0] mag;
  } dtdg_rom_t;

endpackage

// *** hw/dtdg_sine_rom.sv ***
// dtdg_sine_rom: quarter-wave sine magnitudes, one registered read port per channel.
// assumes addresses 0..16; magnitude 32 stands for 1.0.
`timescale 1ns/10ps
module dtdg_sine_rom
  import dtdg_pkg::*;
#(
  parameter int NPORT = NCH
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [NPORT-1:0][LUT_AW-1:0] addr,
  output logic [NPORT-1:0][MAGW-1:0] mag
);

  // 64-point quarter table; coarser periods read every 2nd, 4th.. entry
  function automatic logic [MAGW-1:0] lut(input logic [LUT_AW-1:0] a);
    case (a)
      5'h00: lut = 6'h00;
      5'h01: lut = 6'h03;
      5'h02: lut = 6'h06;
      5'h03: lut = 6'h09;
      5'h04: lut = 6'h0C;
      5'h05: lut = 6'h0F;
      5'h06: lut = 6'h12;
      5'h07: lut = 6'h15;
      5'h08: lut = 6'h18;
      5'h09: lut = 6'h19;
      5'h0A: lut = 6'h1B;
      5'h0B: lut = 6'h1C;
      5'h0C: lut = 6'h1E;
      5'h0D: lut = 6'h1F;
      5'h0E: lut = 6'h1F;
      default: lut = 6'h20;
    endcase
  endfunction

  genvar g;
  generate
    for (g = 0; g < NPORT; g++) begin : g_port
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          mag[g] <= '0;
        end else begin
          mag[g] <= lut(addr[g]);
        end
      end
    end
  endgenerate

endmodule // dtdg_sine_rom

// *** hw/dtdg_gen.sv ***
// dtdg_gen: eight-channel A/B toggle and sine dither code generator with AHB-Lite registers.
// assumes toggle pins synchronous to hclk; dac_code feeds the converter cores directly.
//
// Functional notes
// - dither index n steps 0..N-1 and wraps, sample sin(2 pi n/N + phase)
// - quarter-wave table gives 0,1 / 0,.75,1 / 0,.375,.75,.9375,1 magnitudes
// - 32 and 64 point tables come from the same 17-entry quarter wave
// - dac input is A plus B times D(n)
// - one new sample per rising edge of the channel's dither clock
// - dither clock is a toggle pin or the software toggle bit, per channel
// - period and phase are set per channel
// - toggle mode switches output on both edges of the toggle clock
// - settings 0x0030 means toggle mode clocked by the third pin
// - mode 1, source 10, period 100 gives 64-sample dither on second pin
// - select bit x steers channel x code writes to A (0) or B (1)
// - enable bit x turns on toggle or dither for channel x
// - a channel not enabled and not mid dither period outputs its A code
// - amplitude code write carries channel in bits 18:16 over 16 data bits; bit 19 must be zero
// - cleared enable in dither finishes the current period, then outputs A
// - toggle clock high shows A, low shows B
// - period codes 000..100 give N of 4, 8, 16, 32, 64
// - phase codes 00..11 give 0, 90, 180, 270 degrees
// - source codes 00 software bit, 01/10/11 first/second/third pin
`timescale 1ns/10ps
module dtdg_gen
  import dtdg_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic toggle_pin_first,
  input wire logic toggle_pin_second,
  input wire logic toggle_pin_third,
  output logic [NCH-1:0][CW-1:0] dac_code
);

  dtdg_state_t st_q, st_d;
  dtdg_rom_t rom_q;
  logic [NCH-1:0][LUT_AW-1:0] rom_addr;

  // period code to shift for the 64-point table; illegal codes act as 64
  function automatic logic [2:0] per_of(input logic [7:0] s);
    per_of = (s[SET_PER_LSB +: 3] > PER_MAX) ? PER_MAX : s[SET_PER_LSB +: 3];
  endfunction

  // position on the 64-point circle: scaled index plus phase quarter
  function automatic logic [5:0] pos_of(input logic [5:0] n, input logic [7:0] s);
    logic [5:0] sc;
    sc = n << (3'h4 - per_of(s));
    pos_of = sc + {s[SET_PH_LSB +: 2], 4'h0};
  endfunction

  function automatic logic [5:0] mask_of(input logic [7:0] s);
    mask_of = 6'((7'h04 << per_of(s)) - 7'h01);
  endfunction

  function automatic logic pick_clk(input logic [1:0] src, input logic sw, input logic p0,
                                    input logic p1, input logic p2);
    case (src)
      SRC_SW: pick_clk = sw;
      SRC_PIN0: pick_clk = p0;
      SRC_PIN1: pick_clk = p1;
      default: pick_clk = p2;
    endcase
  endfunction

  function automatic logic [31:0] read_word(input dtdg_state_t s, input logic [7:0] a);
    read_word = '0;
    if (a == OFF_AB) begin
      read_word[NCH-1:0] = s.ab;
    end else if (a == OFF_TB) begin
      read_word[NCH-1:0] = s.tb;
    end else if (a == OFF_EN) begin
      read_word[NCH-1:0] = s.en;
    end else if (a == OFF_ACT) begin
      read_word[NCH-1:0] = s.act;
    end else if (a >= OFF_SET && a < OFF_DAC) begin
      read_word[7:0] = s.set[3'(a[7:2] - OFF_SET[7:2])];
    end else if (a >= OFF_DAC && a < OFF_ACT) begin
      read_word[CW-1:0] = s.dac[3'(a[7:2] - OFF_DAC[7:2])];
    end
  endfunction

  // quadrant fold of the circle position onto the quarter table
  always_comb begin
    logic [5:0] p;
    p = '0;
    for (int i = 0; i < NCH; i++) begin
      p = pos_of(st_q.idx[i], st_q.set[i]);
      rom_addr[i] = p[4] ? LUT_AW'(LUT_TOP - {1'b0, p[3:0]}) : {1'b0, p[3:0]};
    end
  end

  dtdg_sine_rom #(
    .NPORT(NCH)
  ) u_rom (
    .hclk(hclk),
    .hresetn(hresetn),
    .addr(rom_addr),
    .mag(rom_q.mag)
  );

  always_comb begin
    logic sel;
    logic [2:0] ch;
    logic [5:0] p;
    logic [CW+LUT_FRAC:0] prod;
    logic [CW+1:0] sum;
    sel = 1'b0;
    ch = '0;
    p = '0;
    prod = '0;
    sum = '0;
    st_d = st_q;
    st_d.ready = 1'b1;
    st_d.resp = 1'b0;
    st_d.wr_pend = 1'b0;
    st_d.rd_pend = 1'b0;

    // bus data phase
    if (st_q.rd_pend) begin
      st_d.rdata = read_word(st_q, st_q.addr);
    end
    if (st_q.wr_pend) begin
      if (st_q.addr == OFF_CODE) begin
        ch = hwdata[CODE_CH_LSB +: 3];
        if (hwdata[CODE_CH_LSB+3] == 1'b0) begin
          if (st_q.ab[ch]) begin
            st_d.b[ch] = hwdata[CW-1:0];
          end else begin
            st_d.a[ch] = hwdata[CW-1:0];
          end
        end
      end else if (st_q.addr == OFF_AB) begin
        st_d.ab = hwdata[NCH-1:0];
      end else if (st_q.addr == OFF_TB) begin
        st_d.tb = hwdata[NCH-1:0];
      end else if (st_q.addr == OFF_EN) begin
        st_d.en = hwdata[NCH-1:0];
      end else if (st_q.addr >= OFF_SET && st_q.addr < OFF_DAC) begin
        st_d.set[3'(st_q.addr[7:2] - OFF_SET[7:2])] = hwdata[7:0];
      end
    end

    // bus address phase; reads take one wait state so writes land first
    if (hsel && hready && htrans[1]) begin
      st_d.addr = (haddr[31:8] == '0 && haddr[1:0] == 2'h0) ? haddr[7:0] : OFF_BAD;
      st_d.wr_pend = hwrite;
      st_d.rd_pend = !hwrite;
      st_d.ready = hwrite;
    end

    // per channel: toggle mux, or one sine sample per dither clock rise
    for (int i = 0; i < NCH; i++) begin
      sel = pick_clk(st_q.set[i][SET_SRC_LSB +: 2], st_q.tb[i], toggle_pin_first,
                     toggle_pin_second, toggle_pin_third);
      st_d.clk_prev[i] = sel;
      if (!st_q.set[i][SET_MODE_BIT]) begin
        st_d.act[i] = 1'b0;
        st_d.pend[i] = 1'b0;
        st_d.idx[i] = '0;
        st_d.dac[i] = (st_q.en[i] && !sel) ? st_q.b[i] : st_q.a[i];
      end else begin
        st_d.pend[i] = 1'b0;
        if (st_q.pend[i]) begin
          prod = (CW+LUT_FRAC+1)'(st_q.b[i]) * (CW+LUT_FRAC+1)'(rom_q.mag[i]);
          sum = {2'b00, st_q.a[i]};
          if (st_q.neg[i]) begin
            sum = sum - (CW+2)'(prod >> LUT_FRAC);
          end else begin
            sum = sum + (CW+2)'(prod >> LUT_FRAC);
          end
          // clamp to the code range
          if (sum[CW+1]) begin
            st_d.dac[i] = '0;
          end else if (sum[CW]) begin
            st_d.dac[i] = '1;
          end else begin
            st_d.dac[i] = sum[CW-1:0];
          end
        end else if (!st_q.act[i]) begin
          st_d.dac[i] = st_q.a[i];
        end
        // a cleared enable only stops at the period boundary
        if (sel && !st_q.clk_prev[i] && (st_q.act[i] || st_q.en[i])) begin
          if (!st_q.en[i] && st_q.act[i] && st_q.idx[i] == '0) begin
            st_d.act[i] = 1'b0;
          end else begin
            p = pos_of(st_q.idx[i], st_q.set[i]);
            st_d.act[i] = 1'b1;
            st_d.pend[i] = 1'b1;
            st_d.neg[i] = p[5];
            st_d.idx[i] = (st_q.idx[i] + 6'h01) & mask_of(st_q.set[i]);
          end
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= '0;
      st_q.ready <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign hreadyout = st_q.ready;
  assign hresp = st_q.resp;
  assign hrdata = st_q.rdata;
  assign dac_code = st_q.dac;

  // channel 0 checks
  logic rise0;
  logic clk0;
  assign clk0 = pick_clk(st_q.set[0][SET_SRC_LSB +: 2], st_q.tb[0], toggle_pin_first,
                         toggle_pin_second, toggle_pin_third);
  assign rise0 = clk0 && !st_q.clk_prev[0];

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_idle_a;
    !st_q.set[0][SET_MODE_BIT] && !st_q.en[0] |=> dac_code[0] == $past(st_q.a[0]);
  endproperty
  a_idle_a: assert property (p_idle_a) else $error("idle channel not showing A");

  property p_tog_hi;
    !st_q.set[0][SET_MODE_BIT] && st_q.en[0] && clk0 |=> dac_code[0] == $past(st_q.a[0]);
  endproperty
  a_tog_hi: assert property (p_tog_hi) else $error("toggle high not showing A");

  property p_tog_lo;
    !st_q.set[0][SET_MODE_BIT] && st_q.en[0] && !clk0 |=> dac_code[0] == $past(st_q.b[0]);
  endproperty
  a_tog_lo: assert property (p_tog_lo) else $error("toggle low not showing B");

  property p_start;
    st_q.set[0][SET_MODE_BIT] && st_q.en[0] && rise0 |=> st_q.act[0] && st_q.pend[0]
      ##1 !st_q.pend[0];
  endproperty
  a_start: assert property (p_start) else $error("dither edge did not yield a sample");

  property p_wrap;
    st_q.set[0][SET_MODE_BIT] && st_q.en[0] && rise0 && st_q.idx[0] == mask_of(st_q.set[0])
      |=> st_q.idx[0] == '0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("dither index did not wrap at N-1");

  property p_hold;
    st_q.set[0][SET_MODE_BIT] && st_q.act[0] && !st_q.en[0] && rise0 && st_q.idx[0] != '0
      |=> st_q.act[0];
  endproperty
  a_hold: assert property (p_hold) else $error("dither stopped mid period");

  property p_full;
    st_q.pend[0] && $past(rom_addr[0]) == LUT_TOP |-> rom_q.mag[0] == 6'h20;
  endproperty
  a_full: assert property (p_full) else $error("table peak is not 1.0");

  property p_zero;
    st_q.pend[0] && rom_q.mag[0] == '0 |=> dac_code[0] == $past(st_q.a[0]);
  endproperty
  a_zero: assert property (p_zero) else $error("zero sample did not give A");

  property p_stop_a;
    st_q.set[0][SET_MODE_BIT] && !st_q.act[0] && !st_q.pend[0]
      |=> dac_code[0] == $past(st_q.a[0]);
  endproperty
  a_stop_a: assert property (p_stop_a) else $error("stopped dither not showing A");

  property p_up;
    st_q.pend[0] && !st_q.neg[0] |=> dac_code[0] >= $past(st_q.a[0]);
  endproperty
  a_up: assert property (p_up) else $error("positive half sample below A");

  property p_down;
    st_q.pend[0] && st_q.neg[0] |=> dac_code[0] <= $past(st_q.a[0]);
  endproperty
  a_down: assert property (p_down) else $error("negative half sample above A");

  property p_rd_wait;
    hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read not answered after one wait");

  c_toggle: cover property (!st_q.set[0][SET_MODE_BIT] && st_q.en[0] && rise0);
  c_dither: cover property (st_q.act[0] && st_q.idx[0] == 6'h3F);
  c_stop: cover property (st_q.act[0] ##1 !st_q.act[0]);
  c_stop64: cover property (st_q.set[0][SET_PER_LSB +: 3] == PER_MAX && $fell(st_q.act[0]));

endmodule // dtdg_gen

// *** verification/dtdg_pin_model.sv ***
// dtdg_pin_model: host side of the three toggle pins, a square wave per pin.
// assumes run and half come from the bench, changed just after a rising hclk edge.
`timescale 1ns/10ps
module dtdg_pin_model (
  input wire logic hclk,
  input wire logic [2:0] run,
  input wire logic [3:0] half,
  output logic [2:0] pin
);
  logic [3:0] cnt_q [3];
  always @(posedge hclk) begin
    for (int i = 0; i < 3; i++) begin
      if (!run[i]) begin
        // pins stand still low outside a burst
        pin[i] <= 1'b0;
        cnt_q[i] <= 4'h0;
      end else if (cnt_q[i] == half - 4'h1) begin
        pin[i] <= ~pin[i];
        cnt_q[i] <= 4'h0;
      end else begin
        cnt_q[i] <= cnt_q[i] + 4'h1;
      end
    end
  end
endmodule // dtdg_pin_model

// *** verification/tb_dac_toggle_dither_generator.sv ***
// tb_dac_toggle_dither_generator: bench for the toggle/dither generator.
// assumes dtdg_pkg, dtdg_gen and dtdg_pin_model are compiled first.
`timescale 1ns/10ps
module tb_dac_toggle_dither_generator import dtdg_pkg::*;;
  logic hclk = 1'b0;
  logic hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0] htrans;
  logic [2:0] hsize, run, pin;
  logic [3:0] half;
  logic [NCH-1:0][CW-1:0] dac_code;
  int mismatches, cmp_count;
  int tab[17] = '{0, 3, 6, 9, 12, 15, 18, 21, 24, 25, 27, 28, 30, 31, 31, 32, 32};

  dtdg_gen dtdg_gen_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .toggle_pin_first(pin[0]),
    .toggle_pin_second(pin[1]), .toggle_pin_third(pin[2]), .dac_code(dac_code));
  dtdg_pin_model dtdg_pin_model_inst (.hclk(hclk), .run(run), .half(half), .pin(pin));

  always #2.5 hclk = ~hclk;

  task automatic stop_test;
    $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] dc(int c);
    return {16'h0000, dac_code[c]};
  endfunction

  // expected code for A=0x8000, B=0x0044 on the 64-point circle
  function automatic logic [31:0] dexp(int k, int n, int ph);
    int p, m;
    p = (k * (64 / n) + ph * 16) % 64;
    m = ((p / 16) % 2) ? tab[16 - p % 16] : tab[p % 16];
    m = (68 * m) >> 5;
    return 32'(p >= 32 ? 32768 - m : 32768 + m);
  endfunction

  task automatic lvl(int i, logic v);
    int t;
    t = 0;
    do begin
      @(posedge hclk);
      t++;
    end while (pin[i] !== v && t < 64);
    if (t >= 64) begin
      mismatches++;
      stop_test;
    end
  endtask

  task automatic wait_rdy;
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (hreadyout !== 1'b1 && i < 64);
    if (i >= 64) begin
      mismatches++;
      stop_test;
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] o, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, o};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    rv = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask

  task automatic wr(input logic [7:0] o, input logic [31:0] d);
    xfer(1'b1, o, d);
  endtask

  task automatic rd(input logic [7:0] o);
    xfer(1'b0, o, 32'h0);
  endtask

  task automatic code(int ch, logic [15:0] c);
    wr(OFF_CODE, {12'h000, 4'(ch), c});
  endtask

  task automatic s_regs;
    rd(8'hFC);
    chk(rv, 32'h0);
    wr(8'hFC, 32'hFFFF_FFFF);
    rd(OFF_SET);
    chk(rv, 32'h0);
    chk(dc(0), 32'h0);
  endtask

  task automatic s_toggle;
    wr(OFF_AB, 32'h0);
    code(0, 16'h2000);
    wr(OFF_AB, 32'h1);
    code(0, 16'h1FFF);
    wr(OFF_SET, 32'h30);
    cyc_chk_a: chk(dc(0), 32'h2000);
    wr(OFF_EN, 32'h1);
    for (int s = 0; s < 4; s++) begin
      wr(OFF_SET, 32'(s << 4));
      if (s == 0) begin
        wr(OFF_TB, 32'h1);
        repeat (3) @(posedge hclk);
        chk(dc(0), 32'h2000);
        wr(OFF_TB, 32'h0);
        repeat (3) @(posedge hclk);
        chk(dc(0), 32'h1FFF);
      end else begin
        run[s - 1] <= 1'b1;
        lvl(s - 1, 1'b1);
        repeat (3) @(posedge hclk);
        chk(dc(0), 32'h2000);
        lvl(s - 1, 1'b0);
        run <= 3'h0;
        repeat (3) @(posedge hclk);
        chk(dc(0), 32'h1FFF);
      end
    end
    rd(OFF_DAC);
    chk(rv, 32'h1FFF);
    wr(OFF_EN, 32'h0);
    repeat (3) @(posedge hclk);
    chk(dc(0), 32'h2000);
  endtask

  task automatic s_dither;
    int n, ph;
    wr(OFF_AB, 32'h0);
    code(0, 16'h8000);
    code(1, 16'h8000);
    wr(OFF_AB, 32'h3);
    code(0, 16'h0044);
    code(1, 16'h0044);
    half <= 4'h5;
    for (int p = 0; p < 5; p++) begin
      n = 4 << p;
      ph = p % 4;
      wr(OFF_SET, 32'(p));
      wr(OFF_SET + 8'h04, 32'(p));
      wr(OFF_SET, 32'(p | 8 | 32 | ph << 6));
      wr(OFF_SET + 8'h04, 32'(p | 8 | 32 | ((ph + 2) % 4) << 6));
      wr(OFF_EN, 32'h3);
      run[1] <= 1'b1;
      for (int k = 0; k <= n; k++) begin
        lvl(1, 1'b1);
        repeat (3) @(posedge hclk);
        chk(dc(0), dexp(k % n, n, ph));
        chk(dc(1), dexp(k % n, n, (ph + 2) % 4));
        lvl(1, 1'b0);
      end
      run <= 3'h0;
      wr(OFF_EN, 32'h0);
      run[1] <= 1'b1;
      for (int k = 1; k <= n; k++) begin
        lvl(1, 1'b1);
        repeat (3) @(posedge hclk);
        chk(dc(0), k < n ? dexp(k, n, ph) : 32'h8000);
        lvl(1, 1'b0);
      end
      run <= 3'h0;
      rd(OFF_ACT);
      chk(rv, 32'h0);
    end
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    run = 3'h0;
    half = 4'h4;
    mismatches = 0;
    cmp_count = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    s_regs;
    s_toggle;
    s_dither;
    stop_test;
  end
endmodule // tb_dac_toggle_dither_generator
